// File: common/qwi_defines.svh
// Constants for the quad wiper serial slave and its bus controller.
// Assumes a 250 MHz system clock; included by bare name.
`ifndef QWI_DEFINES_SVH
`define QWI_DEFINES_SVH

// =============================================================
// Clock and timing
`define QWI_CLK_MHZ        250
`define QWI_PWRUP_NS       1000
`define QWI_PWRUP_CYC      ((`QWI_PWRUP_NS * `QWI_CLK_MHZ + 999) / 1000)
`define QWI_SCL_PERIOD_NS  2500
`define QWI_QTR_CYC        ((`QWI_SCL_PERIOD_NS * `QWI_CLK_MHZ + 3999) / 4000)

// =============================================================
// Device side
`define QWI_WIPER_RESET    8'h80
`define QWI_ID_PREFIX      5'h0A

// =============================================================
// Controller registers (byte offsets)
`define QWI_CMD_OFS        32'h0000_0000
`define QWI_TXDATA_OFS     32'h0000_0004
`define QWI_RXDATA_OFS     32'h0000_0008
`define QWI_STATUS_OFS     32'h0000_000C
`define QWI_CMD_START      0
`define QWI_CMD_STOP       1
`define QWI_CMD_WRITE      2
`define QWI_CMD_READ       3
`define QWI_CMD_NACK       4
`define QWI_STAT_BUSY      0
`define QWI_STAT_ACKED     1

`endif

// File: common/qwi_if.sv
// Two-wire link between the bus controller and the quad wiper slave.
// Lines are open drain with pull-ups; levels are resolved here.
`timescale 1ns/1ps

interface qwi_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;

  // =============================================================
  // Wired-AND with pull-up
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !(sda_m_oe && !sda_m_o) && !(sda_d_oe && !sda_d_o);

  modport dev  (input scl, input sda, output sda_d_o, output sda_d_oe);
  modport host (input scl, input sda, output scl_m_o, output scl_m_oe,
                output sda_m_o, output sda_m_oe);
endinterface : qwi_if

// File: common/qwi_pkg.sv
// Types shared by both ends of the quad wiper serial link.
// Assumes qwi_defines.svh for all numeric constants.
package qwi_pkg;

  // =============================================================
  // Device states
  typedef enum logic [4:0] {
    QWI_ST_IDLE = 5'h01,
    QWI_ST_RX   = 5'h02,
    QWI_ST_ACK  = 5'h04,
    QWI_ST_TX   = 5'h08,
    QWI_ST_MACK = 5'h10
  } qwi_dev_state_t;

  typedef enum logic [2:0] {
    QWI_BK_ID   = 3'h1,
    QWI_BK_ADDR = 3'h2,
    QWI_BK_DATA = 3'h4
  } qwi_byte_kind_t;

  // =============================================================
  // Controller states
  typedef enum logic [3:0] {
    QWI_M_IDLE  = 4'h1,
    QWI_M_START = 4'h2,
    QWI_M_BIT   = 4'h4,
    QWI_M_STOP  = 4'h8
  } qwi_host_state_t;

endpackage : qwi_pkg

// File: rtl/qwi_device.sv
// Quad wiper serial slave: four 8-bit wiper registers behind a two-wire link.
// Assumes the link lines are asynchronous to hclk and resolved by qwi_if.
//
`timescale 1ns/1ps
`include "qwi_defines.svh"

module qwi_device
  import qwi_pkg::*;
(
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            clk_en,
  input  wire logic            address_strap_upper,
  input  wire logic            address_strap_lower,
  qwi_if.dev                   link,
  output logic [3:0][7:0]      wiper_tap,
  output logic                 standby
);

  // =============================================================
  // Input synchronisers
  logic [2:0]          scl_sy_r;
  logic [2:0]          sda_sy_r;
  logic [1:0]          strap_a_r;
  logic [1:0]          strap_b_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_sy_r  <= 3'h7;
      sda_sy_r  <= 3'h7;
      strap_a_r <= 2'h0;
      strap_b_r <= 2'h0;
    end
    else if (clk_en)
    begin
      scl_sy_r  <= {scl_sy_r[1:0], link.scl};
      sda_sy_r  <= {sda_sy_r[1:0], link.sda};
      strap_a_r <= {strap_a_r[0], address_strap_upper};
      strap_b_r <= {strap_b_r[0], address_strap_lower};
    end
  end

  // =============================================================
  // Line events
  wire scl_hi   = scl_sy_r[1];
  wire sda_hi   = sda_sy_r[1];
  wire scl_rise = scl_sy_r[1] && !scl_sy_r[2];
  wire scl_fall = !scl_sy_r[1] && scl_sy_r[2];
  wire scl_held = scl_sy_r[1] && scl_sy_r[2];
  wire start_ev = scl_held && !sda_sy_r[1] && sda_sy_r[2];
  wire stop_ev  = scl_held && sda_sy_r[1] && !sda_sy_r[2];

  // =============================================================
  // State
  qwi_dev_state_t      state_r;
  qwi_dev_state_t      state_nxt;
  qwi_byte_kind_t      kind_r;
  qwi_byte_kind_t      kind_nxt;
  logic [3:0]          cnt_r;
  logic [3:0]          cnt_nxt;
  logic [7:0]          shift_r;
  logic [7:0]          shift_nxt;
  logic                rd_r;
  logic                rd_nxt;
  logic [1:0]          ptr_r;
  logic [1:0]          ptr_nxt;
  logic                mack_r;
  logic                mack_nxt;
  logic                oe_r;
  logic                oe_nxt;
  logic                wr_en;
  logic [15:0]         pwr_cnt_r;
  logic                standby_r;
  logic [7:0]          wiper_r [4];

  wire pwr_done = (pwr_cnt_r == 16'(`QWI_PWRUP_CYC));
  wire id_ok    = (shift_r[7:3] == `QWI_ID_PREFIX)
               && (shift_r[2:1] == {strap_a_r[1], strap_b_r[1]});
  wire [7:0] rd_byte = wiper_r[ptr_r];

  // =============================================================
  // Next-state decode
  always_comb
  begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    cnt_nxt   = cnt_r;
    shift_nxt = shift_r;
    rd_nxt    = rd_r;
    ptr_nxt   = ptr_r;
    mack_nxt  = mack_r;
    oe_nxt    = oe_r;
    wr_en     = 1'b0;
    if (stop_ev)
    begin
      state_nxt = QWI_ST_IDLE;
      oe_nxt    = 1'b0;
    end
    else if (start_ev && pwr_done)
    begin
      state_nxt = QWI_ST_RX;
      kind_nxt  = QWI_BK_ID;
      cnt_nxt   = 4'h0;
      oe_nxt    = 1'b0;
    end
    else
    begin
      unique case (state_r)
        QWI_ST_IDLE:
        begin
          oe_nxt = 1'b0;
        end
        QWI_ST_RX:
        begin
          if (scl_rise && cnt_r != 4'h8)
          begin
            shift_nxt = {shift_r[6:0], sda_hi};
            cnt_nxt   = cnt_r + 4'h1;
          end
          else if (scl_fall && cnt_r == 4'h8)
          begin
            if (kind_r == QWI_BK_ID && !id_ok)
            begin
              state_nxt = QWI_ST_IDLE;
            end
            else
            begin
              state_nxt = QWI_ST_ACK;
              oe_nxt    = 1'b1;
            end
            if (kind_r == QWI_BK_ID)
            begin
              rd_nxt = shift_r[0];
            end
            if (kind_r == QWI_BK_ADDR)
            begin
              ptr_nxt = shift_r[1:0];
            end
            wr_en = (kind_r == QWI_BK_DATA);
          end
        end
        QWI_ST_ACK:
        begin
          if (scl_fall)
          begin
            cnt_nxt = 4'h0;
            if (kind_r == QWI_BK_ID && rd_r)
            begin
              state_nxt = QWI_ST_TX;
              shift_nxt = rd_byte;
              oe_nxt    = !rd_byte[7];
            end
            else if (kind_r == QWI_BK_DATA)
            begin
              state_nxt = QWI_ST_IDLE;
              oe_nxt    = 1'b0;
            end
            else
            begin
              state_nxt = QWI_ST_RX;
              kind_nxt  = (kind_r == QWI_BK_ID) ? QWI_BK_ADDR : QWI_BK_DATA;
              oe_nxt    = 1'b0;
            end
          end
        end
        QWI_ST_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_r == 4'h7)
            begin
              state_nxt = QWI_ST_MACK;
              oe_nxt    = 1'b0;
              ptr_nxt   = ptr_r + 2'h1;
            end
            else
            begin
              cnt_nxt   = cnt_r + 4'h1;
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_nxt    = !shift_r[6];
            end
          end
        end
        QWI_ST_MACK:
        begin
          if (scl_rise)
          begin
            mack_nxt = !sda_hi;
          end
          else if (scl_fall)
          begin
            cnt_nxt = 4'h0;
            if (mack_r)
            begin
              state_nxt = QWI_ST_TX;
              shift_nxt = rd_byte;
              oe_nxt    = !rd_byte[7];
            end
            else
            begin
              state_nxt = QWI_ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // =============================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r   <= QWI_ST_IDLE;
      kind_r    <= QWI_BK_ID;
      cnt_r     <= 4'h0;
      shift_r   <= 8'h00;
      rd_r      <= 1'b0;
      ptr_r     <= 2'h0;
      mack_r    <= 1'b0;
      oe_r      <= 1'b0;
      standby_r <= 1'b1;
    end
    else if (clk_en)
    begin
      state_r   <= state_nxt;
      kind_r    <= kind_nxt;
      cnt_r     <= cnt_nxt;
      shift_r   <= shift_nxt;
      rd_r      <= rd_nxt;
      ptr_r     <= ptr_nxt;
      mack_r    <= mack_nxt;
      oe_r      <= oe_nxt;
      standby_r <= (state_nxt == QWI_ST_IDLE);
    end
  end

  // Power-up window: starts are not honoured until it has elapsed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pwr_cnt_r <= 16'h0000;
    end
    else if (clk_en && !pwr_done)
    begin
      pwr_cnt_r <= pwr_cnt_r + 16'h0001;
    end
  end

  // =============================================================
  // Wiper registers, code drives the tap directly
  for (genvar i = 0; i < 4; i++)
  begin : g_wiper
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        wiper_r[i] <= `QWI_WIPER_RESET;
      end
      else if (clk_en && wr_en && ptr_r == 2'(i))
      begin
        wiper_r[i] <= shift_r;
      end
    end
    assign wiper_tap[i] = wiper_r[i];
  end

  // =============================================================
  // Link outputs; open drain, only ever pulls low
  logic                sda_o_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sda_o_r <= 1'b0;
    end
    else if (clk_en)
    begin
      sda_o_r <= 1'b0;
    end
  end

  assign link.sda_d_o  = sda_o_r;
  assign link.sda_d_oe = oe_r;
  assign standby       = standby_r;

  wire unused_scl = scl_hi;

endmodule : qwi_device

// File: rtl/qwi_host.sv
// Bus controller for the quad wiper slave, commanded over AHB-Lite.
// Assumes a single zero-wait slave position on the bus; drives SCL itself.
`timescale 1ns/1ps
`include "qwi_defines.svh"

module qwi_host
  import qwi_pkg::*;
(
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            clk_en,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic            hready,
  input  wire logic [31:0]     hwdata,
  output logic [31:0]          hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  qwi_if.host                  link
);

  // =============================================================
  // AHB-Lite slave, zero wait states
  logic                wr_pend_r;
  logic [31:0]         addr_r;
  logic [31:0]         hrdata_r;
  logic [4:0]          cmd_r;
  logic [7:0]          tx_r;
  logic [8:0]          rx9_r;
  logic                busy_r;

  wire acc      = hsel && hready && htrans[1];
  wire go       = wr_pend_r && (addr_r == `QWI_CMD_OFS) && !busy_r;
  wire tx_wr    = wr_pend_r && (addr_r == `QWI_TXDATA_OFS);
  wire [31:0] status = {30'h0, !rx9_r[0], busy_r};
  wire [31:0] rd_mux =
      (haddr == `QWI_CMD_OFS)    ? {27'h0, cmd_r} :
      (haddr == `QWI_TXDATA_OFS) ? {24'h0, tx_r} :
      (haddr == `QWI_RXDATA_OFS) ? {24'h0, rx9_r[8:1]} :
      (haddr == `QWI_STATUS_OFS) ? status : 32'h0;
  wire unused_size = ^hsize;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      addr_r    <= 32'h0;
      hrdata_r  <= 32'h0;
    end
    else if (clk_en)
    begin
      wr_pend_r <= acc && hwrite;
      addr_r    <= haddr;
      if (acc && !hwrite)
      begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // =============================================================
  // Line sequencer, quarter-period ticks
  qwi_host_state_t     st_r;
  logic [1:0]          q_r;
  logic [3:0]          bc_r;
  logic [8:0]          sh9_r;
  logic [15:0]         div_r;
  logic                scl_r;
  logic                sda_r;
  logic [1:0]          sda_sy_r;

  wire tick = (div_r == 16'(`QWI_QTR_CYC - 1));
  wire after_start = (cmd_r[`QWI_CMD_WRITE] || cmd_r[`QWI_CMD_READ]) ? 1'b1 : 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_r    <= 16'h0;
      sda_sy_r <= 2'h3;
    end
    else if (clk_en)
    begin
      div_r    <= tick ? 16'h0 : div_r + 16'h1;
      sda_sy_r <= {sda_sy_r[0], link.sda};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r   <= QWI_M_IDLE;
      q_r    <= 2'h0;
      bc_r   <= 4'h0;
      sh9_r  <= 9'h1FF;
      rx9_r  <= 9'h1FF;
      cmd_r  <= 5'h0;
      tx_r   <= 8'h0;
      busy_r <= 1'b0;
      scl_r  <= 1'b1;
      sda_r  <= 1'b1;
    end
    else if (clk_en)
    begin
      if (tx_wr)
      begin
        tx_r <= hwdata[7:0];
      end
      unique case (st_r)
        QWI_M_IDLE:
        begin
          if (go)
          begin
            cmd_r  <= hwdata[4:0];
            busy_r <= 1'b1;
            q_r    <= 2'h0;
            bc_r   <= 4'h0;
            sh9_r  <= hwdata[`QWI_CMD_WRITE] ? {tx_r, 1'b1}
                                            : {8'hFF, hwdata[`QWI_CMD_NACK]};
            st_r   <= hwdata[`QWI_CMD_START] ? QWI_M_START :
                      (hwdata[`QWI_CMD_WRITE] || hwdata[`QWI_CMD_READ]) ? QWI_M_BIT :
                      hwdata[`QWI_CMD_STOP] ? QWI_M_STOP : QWI_M_IDLE;
            if (hwdata[4:0] == 5'h0)
            begin
              busy_r <= 1'b0;
            end
          end
        end
        QWI_M_START:
        begin
          if (tick)
          begin
            q_r <= q_r + 2'h1;
            unique case (q_r)
              2'h0: sda_r <= 1'b1;
              2'h1: scl_r <= 1'b1;
              2'h2: sda_r <= 1'b0;
              2'h3:
              begin
                scl_r <= 1'b0;
                st_r  <= after_start ? QWI_M_BIT :
                         cmd_r[`QWI_CMD_STOP] ? QWI_M_STOP : QWI_M_IDLE;
                busy_r <= after_start || cmd_r[`QWI_CMD_STOP];
              end
            endcase
          end
        end
        QWI_M_BIT:
        begin
          if (tick)
          begin
            q_r <= q_r + 2'h1;
            unique case (q_r)
              2'h0: sda_r <= sh9_r[8];
              2'h1: scl_r <= 1'b1;
              2'h2: rx9_r <= {rx9_r[7:0], sda_sy_r[1]};
              2'h3:
              begin
                scl_r <= 1'b0;
                sh9_r <= {sh9_r[7:0], 1'b1};
                bc_r  <= bc_r + 4'h1;
                if (bc_r == 4'h8)
                begin
                  st_r   <= cmd_r[`QWI_CMD_STOP] ? QWI_M_STOP : QWI_M_IDLE;
                  busy_r <= cmd_r[`QWI_CMD_STOP];
                end
              end
            endcase
          end
        end
        QWI_M_STOP:
        begin
          if (tick)
          begin
            q_r <= q_r + 2'h1;
            unique case (q_r)
              2'h0: sda_r <= 1'b0;
              2'h1: scl_r <= 1'b1;
              2'h2: sda_r <= 1'b1;
              2'h3:
              begin
                st_r   <= QWI_M_IDLE;
                busy_r <= 1'b0;
              end
            endcase
          end
        end
      endcase
    end
  end

  // =============================================================
  // Outputs; lines are open drain, driven only when low
  logic                zero_r;
  logic                okay_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      zero_r <= 1'b0;
      okay_r <= 1'b1;
    end
    else if (clk_en)
    begin
      zero_r <= 1'b0;
      okay_r <= 1'b1;
    end
  end

  assign hrdata        = hrdata_r;
  assign hreadyout     = okay_r;
  assign hresp         = zero_r;
  assign link.scl_m_o  = zero_r;
  assign link.scl_m_oe = !scl_r;
  assign link.sda_m_o  = zero_r;
  assign link.sda_m_oe = !sda_r;

endmodule : qwi_host

// File: test/quad_wiper_i2c_slave_test.sv
// Bench for the controller and wiper slave joined by qwi_if.
// Assumes the controller register map and command bits of qwi_defines.svh.
`timescale 1ns/1ps
`include "qwi_defines.svh"

module quad_wiper_i2c_slave_test;
  logic             hclk    = 1'b0;
  logic             hresetn = 1'b0;
  logic             hsel    = 1'b0;
  logic             hwrite  = 1'b0;
  logic [1:0]       htrans  = 2'h0;
  logic [2:0]       hsize   = 3'h2;
  logic [31:0]      haddr   = 32'h0;
  logic [31:0]      hwdata  = 32'h0;
  logic [31:0]      rd;
  wire logic [31:0] hrdata;
  wire logic        hreadyout;
  wire logic        hresp;
  wire logic [3:0][7:0] wiper_tap;
  wire logic        standby;
  int               failures = 0;
  int               checks   = 0;

  qwi_if qwi_if_i ();
  qwi_host qwi_host_i (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(qwi_if_i));
  qwi_device qwi_device_i (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .address_strap_upper(1'b1), .address_strap_lower(1'b0), .link(qwi_if_i),
    .wiper_tap(wiper_tap), .standby(standby));
  qwi_link_monitor #(.STRAP(2'h2)) qwi_link_monitor_i (.hclk(hclk), .hresetn(hresetn),
    .scl(qwi_if_i.scl), .sda(qwi_if_i.sda), .sda_d_oe(qwi_if_i.sda_d_oe));

  initial
  begin
    forever #2 hclk = ~hclk;
  end

  // =============================================================
  // Report, compare and bus tasks
  task automatic give_verdict();
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 64);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 64);
    r = hrdata;
    if (n >= 64)
    begin
      failures++;
      give_verdict();
    end
  endtask : ahb

  // One byte with optional START and STOP, then poll and compare the ack bit
  task automatic cmd(input logic [7:0] tx, input logic [4:0] c, input logic ack);
    int n;
    n = 0;
    ahb(1'b1, `QWI_TXDATA_OFS, {24'h0, tx}, rd);
    ahb(1'b1, `QWI_CMD_OFS, {27'h0, c}, rd);
    // Busy may lag the command write by a cycle or two
    repeat (4) @(posedge hclk);
    do ahb(1'b0, `QWI_STATUS_OFS, 32'h0, rd); while (rd[0] !== 1'b0 && ++n < 8000);
    if (n >= 8000)
    begin
      failures++;
      give_verdict();
    end
    chk("acked", {31'h0, ack}, {31'h0, rd[1]});
  endtask : cmd

  task automatic rx(input logic [7:0] exp);
    ahb(1'b0, `QWI_RXDATA_OFS, 32'h0, rd);
    chk("rxdata", {24'h0, exp}, {24'h0, rd[7:0]});
  endtask : rx

  // =============================================================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge hclk);
    chk("wipers", 32'h8080_8080, wiper_tap);
    chk("standby", 32'h1, {31'h0, standby});
    hresetn <= 1'b1;
    repeat (300) @(posedge hclk);
    cmd(8'h52, 5'h07, 1'b0);
    cmd(8'h54, 5'h05, 1'b1);
    cmd(8'h07, 5'h04, 1'b1);
    cmd(8'h35, 5'h06, 1'b1);
    chk("wipers", 32'h3580_8080, wiper_tap);
    chk("standby", 32'h1, {31'h0, standby});
    cmd(8'h54, 5'h05, 1'b1);
    cmd(8'h03, 5'h04, 1'b1);
    cmd(8'h55, 5'h05, 1'b1);
    cmd(8'h00, 5'h08, 1'b1);
    rx(8'h35);
    cmd(8'h00, 5'h1A, 1'b0);
    rx(8'h80);
    ahb(1'b0, 32'h10, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    chk("standby", 32'h1, {31'h0, standby});
    give_verdict();
  end
endmodule : quad_wiper_i2c_slave_test

// File: test/qwi_link_monitor.sv
// Checker for the two-wire link between the controller and the wiper slave.
// Assumes raw interface levels; STRAP gives the levels on the two strap pins.
`timescale 1ns/1ps

module qwi_link_monitor
#(
  parameter logic [1:0] STRAP = 2'h0
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_oe
);
  logic       scl_r;
  logic       sda_r;
  logic       ok_r;
  logic       rd_r;
  logic       park_r;
  logic [3:0] bit_r;
  logic [1:0] nbyte_r;
  logic [6:0] sh_r;
  logic [8:0] up_r;
  wire start_w = scl_r && scl && sda_r && !sda;
  wire stop_w  = scl_r && scl && !sda_r && sda;
  wire rise_w  = !scl_r && scl;
  wire ninth_w = rise_w && (bit_r == 4'h8);

  // =============================================================
  // Byte framing as seen on the wire
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {scl_r, sda_r, park_r} <= 3'h7;
      {ok_r, rd_r, bit_r, nbyte_r, sh_r, up_r} <= '0;
    end
    else
    begin
      scl_r <= scl;
      sda_r <= sda;
      if (up_r != 9'h1FF)
        up_r <= up_r + 9'h001;
      if (start_w)
      begin
        bit_r   <= 4'h0;
        nbyte_r <= 2'h0;
        park_r  <= 1'b0;
      end
      else if (stop_w)
        park_r <= 1'b1;
      else if (rise_w)
      begin
        sh_r  <= {sh_r[5:0], sda};
        bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
        if (bit_r == 4'h7 && nbyte_r == 2'h0)
        begin
          ok_r <= (sh_r[6:2] == 5'h0A) && (sh_r[1:0] == STRAP);
          rd_r <= sda;
        end
        if (bit_r == 4'h8 && nbyte_r != 2'h3)
          nbyte_r <= nbyte_r + 2'h1;
      end
    end
  end

  // =============================================================
  // Device side of the link
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  dev_edge_a: assert property ($changed(sda_d_oe) |-> !scl && !$past(scl) && !$past(scl, 2))
    else $error("device moved sda while scl high");
  dev_quiet_a: assert property (up_r < 9'd250 |-> !sda_d_oe)
    else $error("device drove sda during power-up");
  id_ack_a: assert property (ninth_w && nbyte_r == 2'h0 |-> sda_d_oe == ok_r)
    else $error("identification ack does not match validity");
  wr_ack_a: assert property (ninth_w && nbyte_r inside {2'h1, 2'h2} && ok_r && !rd_r |-> sda_d_oe)
    else $error("write byte not acknowledged");
  rd_release_a: assert property (ninth_w && nbyte_r != 2'h0 && ok_r && rd_r |-> !sda_d_oe)
    else $error("device held sda in master ack slot");
  bad_quiet_a: assert property (nbyte_r != 2'h0 && !ok_r |-> !sda_d_oe)
    else $error("device drove sda after bad identification");
  parked_a: assert property (park_r |-> !sda_d_oe)
    else $error("device drove sda outside a transfer");
  ack_hold_a: assert property (ninth_w && sda_d_oe |=> sda_d_oe [*8])
    else $error("ack released during clock high");
endmodule : qwi_link_monitor
